// ===== hw/brg_top.v
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "brg_consts.vh"
`default_nettype none
module brg_top #(
	parameter DIV_W = 8
) (
	input wire MCLK_I,
	input wire RST_I,
	input wire CE_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [7:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	input wire HELPER_TIMER_I,
	input wire TX_WRITE_I,
	input wire TX_MORE_I,
	input wire TX_FRAME_END_I,
	input wire RXD_I,
	output reg BASE_CLK_O,
	output reg TX_BIT_CLK_O,
	output reg TX_BIT_EDGE_O,
	output reg RX_SAMPLE_O,
	output reg RX_START_O,
	output reg RX_ACTIVE_O
);
	reg [3:0] clksel_r;
	reg [7:0] div_r;
	reg pwr_r;
	reg txe_r;
	reg rxe_r;
	reg [`BRG_PRE_W-1:0] pre_r;
	reg [`BRG_PRE_W-1:0] pre_prev_r;
	reg tmr_s1_r;
	reg tmr_s2_r;
	reg tmr_s3_r;
	reg rxd_s1_r;
	reg rxd_s2_r;
	reg rxd_f_r;
	reg rxd_prev_r;
	reg tick_r;
	reg tx_run_r;
	reg gap_r;
	reg [1:0] gap_cnt_r;
	reg rx_run_r;
	reg [3:0] rx_bits_r;
	reg [31:0] rdata_nxt;
	reg tick_nxt;
	wire [7:0] k_eff;
	wire tx_clr;
	wire rx_clr;
	wire tx_half;
	wire tx_clk;
	wire tx_edge;
	wire rx_half;
	wire rx_clk;
	wire rx_edge;
	wire rx_start;
	wire wr_acc;
	wire rd_acc;

	// a write lands at the edge where the master sees the access acknowledged
	assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
	assign rd_acc = PSEL_I && !PENABLE_I && !PWRITE_I;

	// clamp protects the counter from a sub-minimum divider value
	assign k_eff = (div_r < `BRG_DIV_MIN) ? `BRG_DIV_MIN : div_r;

	always @* begin
		case (PADDR_I)
		`BRG_ADDR_CLKSEL: rdata_nxt = {28'h0000000, clksel_r};
		`BRG_ADDR_DIV: rdata_nxt = {24'h000000, div_r};
		`BRG_ADDR_CTRL: rdata_nxt = {24'h000000, pwr_r, txe_r, rxe_r, 5'h00};
		`BRG_ADDR_STAT: rdata_nxt = {28'h0000000, gap_r, rx_run_r, rx_clk, tx_clk};
		default: rdata_nxt = 32'h00000000;
		endcase
	end

	// apb slave: no wait states, answer in the access cycle after setup
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O <= 32'h00000000;
			clksel_r <= `BRG_CLKSEL_RST;
			div_r <= `BRG_DIV_RST;
			pwr_r <= 1'b0;
			txe_r <= 1'b0;
			rxe_r <= 1'b0;
		end else if (CE_I) begin
			PREADY_O <= PSEL_I && !PENABLE_I;
			PSLVERR_O <= PSEL_I && !PENABLE_I && (PADDR_I > `BRG_ADDR_STAT ||
				PADDR_I[1:0] != 2'h0);
			if (rd_acc) begin
				PRDATA_O <= rdata_nxt;
			end
			if (wr_acc) begin
				case (PADDR_I)
				`BRG_ADDR_CLKSEL: begin
					// prohibited codes are not stored
					if (PWDATA_I[3:0] <= `BRG_SEL_TIMER) begin
						clksel_r <= PWDATA_I[3:0];
					end
				end
				`BRG_ADDR_DIV: div_r <= PWDATA_I[7:0];
				`BRG_ADDR_CTRL: begin
					pwr_r <= PWDATA_I[`BRG_CTRL_PWR];
					txe_r <= PWDATA_I[`BRG_CTRL_TXE];
					rxe_r <= PWDATA_I[`BRG_CTRL_RXE];
				end
				default: begin
				end
				endcase
			end
		end
	end

	// prescaler and pin synchronisers
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			pre_r <= {`BRG_PRE_W{1'b0}};
			pre_prev_r <= {`BRG_PRE_W{1'b0}};
			tmr_s1_r <= 1'b0;
			tmr_s2_r <= 1'b0;
			tmr_s3_r <= 1'b0;
			rxd_s1_r <= 1'b1;
			rxd_s2_r <= 1'b1;
			rxd_f_r <= 1'b1;
			rxd_prev_r <= 1'b1;
			tick_r <= 1'b0;
			BASE_CLK_O <= 1'b0;
		end else if (CE_I) begin
			pre_r <= pwr_r ? pre_r + {{(`BRG_PRE_W-1){1'b0}}, 1'b1} : {`BRG_PRE_W{1'b0}};
			pre_prev_r <= pre_r;
			tmr_s1_r <= HELPER_TIMER_I;
			tmr_s2_r <= tmr_s1_r;
			tmr_s3_r <= tmr_s2_r;
			rxd_s1_r <= RXD_I;
			rxd_s2_r <= rxd_s1_r;
			// two matching samples change the filtered level
			if (tick_r && rxd_s2_r == rxd_prev_r) begin
				rxd_f_r <= rxd_s2_r;
			end
			if (tick_r) begin
				rxd_prev_r <= rxd_s2_r;
			end
			tick_r <= tick_nxt && pwr_r;
			BASE_CLK_O <= tick_nxt && pwr_r;
		end
	end

	// base tick: a rising edge of the selected divided clock, or every cycle for select code 0
	always @* begin
		tick_nxt = 1'b0;
		if (clksel_r == 4'h0) begin
			tick_nxt = 1'b1;
		end else if (clksel_r == `BRG_SEL_TIMER) begin
			tick_nxt = tmr_s2_r && !tmr_s3_r;
		end else if (clksel_r < `BRG_SEL_TIMER) begin
			tick_nxt = pre_r[clksel_r - 4'h1] && !pre_prev_r[clksel_r - 4'h1];
		end
	end

	// transmit path: gap of two base clocks between back-to-back frames
	assign tx_clr = !pwr_r || !txe_r || gap_r ||
		(TX_WRITE_I && !tx_run_r);

	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			tx_run_r <= 1'b0;
			gap_r <= 1'b0;
			gap_cnt_r <= 2'h0;
		end else if (CE_I) begin
			if (!pwr_r || !txe_r) begin
				tx_run_r <= 1'b0;
				gap_r <= 1'b0;
				gap_cnt_r <= 2'h0;
			end else if (gap_r) begin
				if (tick_r) begin
					gap_cnt_r <= gap_cnt_r + 2'h1;
					if (gap_cnt_r == `BRG_GAP_CLKS - 2'h1) begin
						gap_r <= 1'b0;
					end
				end
			end else if (TX_WRITE_I) begin
				tx_run_r <= 1'b1;
			end else if (TX_FRAME_END_I && TX_MORE_I) begin
				gap_r <= 1'b1;
				gap_cnt_r <= 2'h0;
			end
		end
	end

	brg_div_ctr #(.W(DIV_W)) u_tx_ctr (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.clr_i(tx_clr),
		.tick_i(tick_r),
		.k_i(k_eff),
		.half_o(tx_half),
		.bit_clk_o(tx_clk),
		.edge_o(tx_edge)
	);

	// receive path: low filtered line on a base tick while idle starts a frame
	assign rx_start = !rx_run_r && rxd_f_r == 1'b0 && tick_r;
	assign rx_clr = !pwr_r || !rxe_r || !rx_run_r;

	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			rx_run_r <= 1'b0;
			rx_bits_r <= 4'h0;
		end else if (CE_I) begin
			if (!pwr_r || !rxe_r) begin
				rx_run_r <= 1'b0;
				rx_bits_r <= 4'h0;
			end else if (rx_start) begin
				rx_run_r <= 1'b1;
				rx_bits_r <= 4'h0;
			end else if (rx_run_r && rx_edge) begin
				rx_bits_r <= rx_bits_r + 4'h1;
				if (rx_bits_r == `BRG_FRAME_BITS - 4'h1) begin
					rx_run_r <= 1'b0;
				end
			end
		end
	end

	brg_div_ctr #(.W(DIV_W)) u_rx_ctr (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.ce_i(CE_I),
		.clr_i(rx_clr),
		.tick_i(tick_r),
		.k_i(k_eff),
		.half_o(rx_half),
		.bit_clk_o(rx_clk),
		.edge_o(rx_edge)
	);

	// outputs: bit rate = base / (2k) since two half periods of k ticks each
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			TX_BIT_CLK_O <= 1'b0;
			TX_BIT_EDGE_O <= 1'b0;
			RX_SAMPLE_O <= 1'b0;
			RX_START_O <= 1'b0;
			RX_ACTIVE_O <= 1'b0;
		end else if (CE_I) begin
			TX_BIT_CLK_O <= tx_clk;
			TX_BIT_EDGE_O <= tx_edge && !tx_clr;
			// sample at mid-bit: half-period boundary with divide-by-two low
			RX_SAMPLE_O <= rx_half && !rx_clk && rx_run_r;
			RX_START_O <= rx_start;
			RX_ACTIVE_O <= rx_run_r;
		end
	end
endmodule
`default_nettype wire

// ===== hw/brg_consts.vh
`ifndef BRG_CONSTS_VH
`define BRG_CONSTS_VH
// register byte addresses on the APB
`define BRG_ADDR_CLKSEL 8'h00
`define BRG_ADDR_DIV 8'h04
`define BRG_ADDR_CTRL 8'h08
`define BRG_ADDR_STAT 8'h0C
// reset values
`define BRG_CLKSEL_RST 4'h0
`define BRG_DIV_RST 8'hFF
// field positions in the control register
`define BRG_CTRL_PWR 7
`define BRG_CTRL_TXE 6
`define BRG_CTRL_RXE 5
// field positions in the status register
`define BRG_STAT_TXCLK 0
`define BRG_STAT_RXCLK 1
`define BRG_STAT_RXRUN 2
`define BRG_STAT_GAP 3
// divider limits and select codes
`define BRG_DIV_MIN 8'h04
`define BRG_SEL_TIMER 4'hB
// timing counts
`define BRG_FRAME_BITS 4'hB
`define BRG_GAP_CLKS 2'h2
`define BRG_PRE_W 10
`endif

// ===== hw/brg_div_ctr.v
`include "brg_consts.vh"
`default_nettype none
// one divider channel: counts base ticks to k, toggles a divide-by-two stage
module brg_div_ctr #(
	parameter W = 8
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire clr_i,
	input wire tick_i,
	input wire [W-1:0] k_i,
	output wire half_o,
	output wire bit_clk_o,
	output wire edge_o
);
	reg [W-1:0] cnt_r;
	reg half_r;
	wire hit;
	assign hit = tick_i && (cnt_r >= k_i - {{(W-1){1'b0}}, 1'b1});
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= {W{1'b0}};
			half_r <= 1'b0;
		end else if (ce_i) begin
			if (clr_i) begin
				cnt_r <= {W{1'b0}};
				half_r <= 1'b0;
			end else if (hit) begin
				cnt_r <= {W{1'b0}};
				half_r <= ~half_r;
			end else if (tick_i) begin
				cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
	assign half_o = hit;
	assign bit_clk_o = half_r;
	assign edge_o = hit && half_r;
endmodule
`default_nettype wire

// ===== dv/brg_chk.sv
`include "brg_consts.vh"
`default_nettype none
module brg_chk(
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic PREADY_O,
	input wire logic BASE_CLK_O,
	input wire logic TX_BIT_CLK_O,
	input wire logic TX_BIT_EDGE_O,
	input wire logic RX_SAMPLE_O,
	input wire logic RX_START_O,
	input wire logic RX_ACTIVE_O
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pwr_r;
	// power bit as seen from completed writes
	always @(posedge MCLK_I or posedge RST_I) begin
		if (RST_I) begin
			pwr_r <= 1'b0;
		end else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && PADDR_I == `BRG_ADDR_CTRL) begin
			pwr_r <= PWDATA_I[`BRG_CTRL_PWR];
		end
	end
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	property p_off_base;
		!pwr_r [*3] |-> !BASE_CLK_O;
	endproperty
	a_off_base: assert property (p_off_base) else $error("base tick unpowered");
	property p_off_tx;
		!pwr_r [*3] |-> !TX_BIT_CLK_O && !TX_BIT_EDGE_O;
	endproperty
	a_off_tx: assert property (p_off_tx) else $error("tx runs unpowered");
	property p_off_rx;
		!pwr_r [*3] |-> !RX_ACTIVE_O && !RX_SAMPLE_O;
	endproperty
	a_off_rx: assert property (p_off_rx) else $error("rx runs unpowered");
	property p_edge;
		TX_BIT_EDGE_O |=> !TX_BIT_EDGE_O [*3];
	endproperty
	a_edge: assert property (p_edge) else $error("bit edges too close");
	property p_samp;
		RX_SAMPLE_O |-> RX_ACTIVE_O;
	endproperty
	a_samp: assert property (p_samp) else $error("sample outside frame");
	property p_start;
		RX_START_O |-> ##[0:2] RX_ACTIVE_O;
	endproperty
	a_start: assert property (p_start) else $error("start without frame");
	property p_stp;
		RX_START_O |=> !RX_START_O;
	endproperty
	a_stp: assert property (p_stp) else $error("start not a pulse");
	property p_act;
		$rose(RX_ACTIVE_O) |-> RX_START_O || $past(RX_START_O) || $past(RX_START_O, 2);
	endproperty
	a_act: assert property (p_act) else $error("frame without start");
endmodule
bind brg_top brg_chk u_chk(.*);
`default_nettype wire

// ===== dv/brg_rem.sv
`default_nettype none
module brg_rem #(
	parameter int PER = 8
) (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [7:0] d_i,
	output logic rxd_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [10:0] f;
	initial rxd_o = 1'b1;
	always @(posedge clk_i) begin
		if (go_i) begin
			// start, data lsb first, parity, stop; idle stays high
			f = {1'b1, ^d_i, d_i, 1'b0};
			for (int i = 0; i < 11; i++) begin
				rxd_o <= f[i];
				repeat (PER) @(posedge clk_i);
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/tb.sv
`include "brg_consts.vh"
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
$display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic MCLK_I = 0, RST_I = 1, CE_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
	logic HELPER_TIMER_I = 0, TX_WRITE_I = 0, TX_MORE_I = 0, TX_FRAME_END_I = 0, RXD_I, go = 0;
	logic [7:0] PADDR_I = 8'h00;
	logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rd;
	logic PREADY_O, PSLVERR_O, BASE_CLK_O, TX_BIT_CLK_O, TX_BIT_EDGE_O, er;
	logic RX_SAMPLE_O, RX_START_O, RX_ACTIVE_O;
	logic [15:0] lf = 16'hD75A;
	int bad_count = 0, check_count = 0, cyc = 0, nb = 0, ns = 0, nst = 0;
	time t0;
	brg_top dut(.*);
	brg_rem u_rem(.clk_i(MCLK_I), .go_i(go), .d_i(lf[7:0]), .rxd_o(RXD_I));
	initial forever #5 MCLK_I = ~MCLK_I;
	// helper timer already counting before the toggle output runs
	always begin
		repeat (3) @(posedge MCLK_I);
		HELPER_TIMER_I <= ~HELPER_TIMER_I;
	end
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function automatic int bper(input int k, input int s);
		return 2 * (k < 4 ? 4 : k) * (s == 11 ? 6 : 1 << s);
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK_I);
		PSEL_I <= 1'b1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge MCLK_I);
		PENABLE_I <= 1'b1;
		do @(posedge MCLK_I); while (PREADY_O !== 1'b1);
		rd = PRDATA_O;
		er = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask
	task automatic meas(input int k, input int s);
		apb(1, `BRG_ADDR_CTRL, 0);
		apb(1, `BRG_ADDR_DIV, k);
		apb(1, `BRG_ADDR_CLKSEL, s);
		apb(1, `BRG_ADDR_CTRL, 32'hE0);
		@(posedge TX_BIT_CLK_O);
		@(posedge TX_BIT_CLK_O);
		t0 = $time;
		@(posedge TX_BIT_CLK_O);
		`CHK("bit period", bper(k, s), int'(($time - t0) / 10))
	endtask
	always @(posedge MCLK_I) begin
		cyc++;
		nb += int'(BASE_CLK_O);
		ns += int'(RX_SAMPLE_O);
		nst += int'(RX_START_O);
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (5) @(posedge MCLK_I);
		RST_I <= 1'b0;
		apb(0, `BRG_ADDR_CLKSEL, 0);
		`CHK("clksel reset", 32'h0, rd)
		apb(0, `BRG_ADDR_DIV, 0);
		`CHK("div reset", 32'hFF, rd)
		apb(0, `BRG_ADDR_CTRL, 0);
		`CHK("ctrl reset", 32'h0, rd)
		for (int i = 0; i < 16; i++) begin
			apb(1, `BRG_ADDR_CLKSEL, i);
			apb(0, `BRG_ADDR_CLKSEL, 0);
			`CHK("clksel", i > 11 ? 32'hB : i, rd)
		end
		apb(0, 8'h10, 0);
		`CHK("unmapped", 33'h100000000, {er, rd})
		meas(2, 0);
		meas(255, 0);
		meas(4, 11);
		repeat (3) begin
			lf = nx(lf);
			meas(4 + lf[2:0], lf[9:8] % 3);
		end
		apb(1, `BRG_ADDR_CTRL, 0);
		repeat (3) @(posedge MCLK_I);
		nb = 0;
		repeat (40) @(posedge MCLK_I);
		`CHK("base off", 0, nb)
		meas(4, 0);
		// first buffer write clears the counter: k ticks plus two register stages
		@(posedge TX_BIT_CLK_O);
		@(posedge MCLK_I);
		TX_WRITE_I <= 1'b1;
		t0 = $time;
		@(posedge MCLK_I);
		TX_WRITE_I <= 1'b0;
		@(posedge TX_BIT_CLK_O);
		`CHK("first write", 6, int'(($time - t0) / 10))
		// back-to-back frame adds two base clocks before counting restarts
		@(posedge MCLK_I);
		TX_FRAME_END_I <= 1'b1;
		TX_MORE_I <= 1'b1;
		t0 = $time;
		@(posedge MCLK_I);
		TX_FRAME_END_I <= 1'b0;
		TX_MORE_I <= 1'b0;
		@(posedge TX_BIT_CLK_O);
		`CHK("frame gap", 8, int'(($time - t0) / 10))
		ns = 0;
		nst = 0;
		repeat (2) begin
			lf = nx(lf);
			go <= 1'b1;
			@(posedge MCLK_I);
			go <= 1'b0;
			repeat (110) @(posedge MCLK_I);
		end
		`CHK("starts", 2, nst)
		`CHK("samples", 22, ns)
		give_verdict();
	end
endmodule
`default_nettype wire
